// ### radio_timing_params.svh
`ifndef RADIO_TIMING_PARAMS_SVH
`define RADIO_TIMING_PARAMS_SVH
// slot and frame grid, in chips and slots
`define SLOT_LAST_CHIP 12'h9FF
`define FRAME_LAST_SLOT 4'hE
`define CHIPS_PER_SLOT 16'hA00
// reference frame counter modulus, a multiple of 72 frames
`define SFN_MODULUS 16'h9000
// access slot spacing in access slots, per indicator timing setting
`define RA_SPACING_SEL0 3'h3
`define RA_SPACING_SEL1 3'h4
// least chips from an acquisition indicator to the next transmission
`define AI_MIN_GAP 13'h1E00
// paging indicator lead over its secondary frame: 3 x 2560 chips, last count
`define PAGING_LEAD_LAST 13'h1DFF
// dedicated frame may trail the shared frame by up to 35840 chips
`define SHARED_BEHIND_MAX 16'h8C00
`endif

// ### radio_timing_pkg.sv
package radio_timing_pkg;
    typedef enum logic [1:0] {RA_IDLE, RA_ARMED, RA_SPACING} ra_state_e;

    typedef struct packed {
        logic [11:0] chip;
        logic [3:0] slot;
        logic [15:0] frame;
        logic slot_start;
        logic frame_start;
    } cnt_state_s;

    typedef struct packed {
        ra_state_e ra;
        logic [2:0] slot_cnt;
        logic ai_got;
        logic ai_pos;
        logic ai_recent;
        logic [12:0] ai_gap;
        logic dl_acc;
        logic ul_acc;
        logic preamble;
        logic message;
        logic fail;
        logic ul_pend;
        logic [15:0] ul_wait;
        logic meas_busy;
        logic [15:0] meas_cnt;
        logic [15:0] ho_diff;
        logic ho_valid;
        logic [15:0] shared_frame;
        logic shared_ahead;
        logic shared_valid;
        logic pg_busy;
        logic pg_hit;
        logic [12:0] pg_cnt;
        logic pg_read;
    } tmg_state_s;

    // frame number step with wrap to zero at the modulus
    function automatic logic [15:0] sfn_step(input logic [15:0] f, input logic [15:0] m);
        return (f == m - 16'h1) ? 16'h0 : f + 16'h1;
    endfunction
endpackage

// ### frame_timing_if.sv
`timescale 1ns/1ns
interface frame_timing_if;
    logic [11:0] chip;
    logic [3:0] slot;
    logic [15:0] frame;
    logic slot_start;
    logic frame_start;
    modport counter(output chip, slot, frame, slot_start, frame_start);
    modport user(input chip, slot, frame, slot_start, frame_start);
endinterface

// ### frame_slot_counter.sv
`timescale 1ns/1ns
`include "radio_timing_params.svh"
module frame_slot_counter
    import radio_timing_pkg::*;
#(
    parameter logic [15:0] SFN_MOD = `SFN_MODULUS
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chip_en,
    input wire logic restart,
    input wire logic sfn_load,
    input wire logic [15:0] sfn_value,
    frame_timing_if.counter tmg
);
    cnt_state_s s;
    cnt_state_s next_s;

    //////////////////////////////////////////////////////////////////////
    // chips into slots, slots into frames, frames into the frame number
    always_comb begin
        next_s = s;
        next_s.slot_start = 1'b0;
        next_s.frame_start = 1'b0;
        if (restart) begin
            // restart marks chip zero of a new frame, whatever the count was
            next_s.chip = 12'h0;
            next_s.slot = 4'h0;
            next_s.frame = sfn_step(s.frame, SFN_MOD);
            next_s.slot_start = 1'b1;
            next_s.frame_start = 1'b1;
        end else if (chip_en) begin
            if (s.chip == `SLOT_LAST_CHIP) begin // R24
                next_s.chip = 12'h0;
                next_s.slot_start = 1'b1;
                if (s.slot == `FRAME_LAST_SLOT) begin
                    next_s.slot = 4'h0;
                    next_s.frame_start = 1'b1;
                    next_s.frame = sfn_step(s.frame, SFN_MOD); // R01
                end else begin
                    next_s.slot = s.slot + 4'h1;
                end
            end else begin
                next_s.chip = s.chip + 12'h1;
            end
        end
        // broadcast frame number read by software overrides the count
        if (sfn_load) begin
            next_s.frame = sfn_value; // R02
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tmg.chip = s.chip;
    assign tmg.slot = s.slot;
    assign tmg.frame = s.frame;
    assign tmg.slot_start = s.slot_start;
    assign tmg.frame_start = s.frame_start;

    //////////////////////////////////////////////////////////////////////
    AST_FRAME_GRID: assert property (@(posedge core_clk) disable iff (srst) // R24
        s.frame_start |-> s.slot_start && s.chip == 12'h0 && s.slot == 4'h0)
        else $error("frame start off the slot grid");
endmodule

// ### radio_frame_timing.sv
`timescale 1ns/1ns
`include "radio_timing_params.svh"
// Summary of operation
// R01 - base station frame counter steps every 10 ms frame, wraps at a multiple of 72
// R02 - each cell broadcasts its frame number; the terminal loads it
// R03 - base station offsets sync, primary frames and scrambling by up to one slot
// R04 - random access timing follows the offset primary frame timing of the cell
// R05 - uplink dedicated frame starts a set offset after earliest dedicated path
// R06 - uplink scrambling restarts its initial phase at each uplink frame boundary
// R07 - measure target primary frame to earliest dedicated path before handover
// R08 - uplink control and data channels share one frame timing
// R09 - downlink control and data channels to one terminal share frame timing
// R10 - shared downlink frames align with the primary control frames
// R11 - dedicated frame lies 2560 chips ahead to 35840 behind shared frame
// R12 - access slots are 5120 chips, each downlink slot has one uplink slot
// R13 - downlink access slots align with the primary frame boundary
// R14 - each preamble starts on an uplink access slot boundary
// R15 - uplink access slot sits 2560 chips from its downlink slot
// R16 - next preamble three or four access slots after the latest one
// R17 - message three or four access slots after the latest preamble
// R18 - base station answers 7680 or 12800 chips after the preamble
// R19 - at least 7680 chips from an indicator to the next preamble
// R20 - at least 7680 chips from an indicator to the message start
// R21 - paging frame leads its secondary frame by three 2560-chip slots
// R22 - a set paging indicator makes the terminal read the secondary frame
// R23 - indicator timing 0 gives 7680 chips and three slots, 1 gives 12800 and four
// R24 - chips count into 2560-chip slots and fifteen-slot frames for all boundaries
module radio_frame_timing
    import radio_timing_pkg::*;
#(
    parameter logic [15:0] SFN_MOD = `SFN_MODULUS
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chip_en,
    input wire logic cell_frame_sync,
    input wire logic sfn_load,
    input wire logic [15:0] sfn_value,
    input wire logic ded_frame_sync,
    input wire logic target_frame_sync,
    input wire logic [15:0] uplink_frame_offset,
    input wire logic ai_timing_sel,
    input wire logic preamble_req,
    input wire logic ai_valid,
    input wire logic ai_ack,
    input wire logic paging_frame_start,
    input wire logic pi_valid,
    input wire logic pi_value,
    output logic dl_slot_start,
    output logic dl_frame_start,
    output logic [15:0] system_frame_counter,
    output logic dl_access_start,
    output logic ul_access_start,
    output logic ul_frame_start,
    output logic ul_scramble_init,
    output logic preamble_start,
    output logic message_start,
    output logic ra_fail,
    output logic [15:0] handover_timing_difference,
    output logic handover_valid,
    output logic [15:0] shared_frame_number,
    output logic shared_ahead,
    output logic shared_valid,
    output logic read_secondary_frame
);
    tmg_state_s s;
    tmg_state_s next_s;
    logic ul_go;
    logic ul_edge;
    logic dl_edge;
    logic gap_ok;
    logic [2:0] spacing;
    logic [15:0] ded_pos;

    frame_timing_if dl_if();
    frame_timing_if ul_if();

    //////////////////////////////////////////////////////////////////////
    // downlink grid restarts on the offset primary frame of the cell
    frame_slot_counter #(.SFN_MOD(SFN_MOD)) u_dl_cnt (
        .core_clk(core_clk),
        .srst(srst),
        .chip_en(chip_en),
        .restart(cell_frame_sync), // R04
        .sfn_load(sfn_load),
        .sfn_value(sfn_value),
        .tmg(dl_if.counter)
    );

    // uplink grid restarts a set offset after the dedicated downlink frame
    frame_slot_counter #(.SFN_MOD(SFN_MOD)) u_ul_cnt (
        .core_clk(core_clk),
        .srst(srst),
        .chip_en(chip_en),
        .restart(ul_go), // R05
        .sfn_load(1'b0),
        .sfn_value(16'h0),
        .tmg(ul_if.counter)
    );

    // chip position of the downlink grid within its frame
    function automatic logic [15:0] frame_pos(input logic [3:0] slot, input logic [11:0] chip);
        return 16'(slot) * `CHIPS_PER_SLOT + 16'(chip);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // access slots span two slots each; parity of slot against frame
    // number places them on a 5120-chip grid anchored at even frames
    assign dl_edge = dl_if.slot_start && (dl_if.slot[0] == dl_if.frame[0]); // R13
    assign ul_edge = dl_if.slot_start && (dl_if.slot[0] != dl_if.frame[0]); // R15
    assign spacing = ai_timing_sel ? `RA_SPACING_SEL1 : `RA_SPACING_SEL0; // R23
    // an indicator arriving now also blocks, so the gap is never cut short
    assign gap_ok = !ai_valid && !s.ai_recent;
    assign ul_go = s.ul_pend && chip_en && (s.ul_wait == 16'h0);
    assign ded_pos = frame_pos(dl_if.slot, dl_if.chip);

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.dl_acc = dl_edge; // R12
        next_s.ul_acc = ul_edge; // R15
        next_s.preamble = 1'b0;
        next_s.message = 1'b0;
        next_s.fail = 1'b0;
        next_s.ho_valid = 1'b0;
        next_s.shared_valid = 1'b0;
        next_s.pg_read = 1'b0;

        // chips since the last acquisition indicator, held once long enough
        if (ai_valid) begin
            next_s.ai_recent = 1'b1;
            next_s.ai_gap = 13'h0;
        end else if (s.ai_recent && chip_en) begin
            next_s.ai_gap = s.ai_gap + 13'h1;
            // drop one count early so an access edge exactly the minimum gap
            // after the indicator is still allowed
            next_s.ai_recent = (s.ai_gap + 13'h2) < `AI_MIN_GAP; // R19 R20
        end

        // random access: preamble, wait the spacing, then message or retry
        unique case (s.ra)
            RA_IDLE: begin
                if (preamble_req) begin
                    next_s.ra = RA_ARMED;
                end
            end
            RA_ARMED: begin
                if (ul_edge && gap_ok) begin // R14 R19
                    next_s.preamble = 1'b1;
                    next_s.slot_cnt = 3'h0;
                    next_s.ai_got = 1'b0;
                    next_s.ra = RA_SPACING;
                end
            end
            RA_SPACING: begin
                if (ai_valid) begin
                    next_s.ai_got = 1'b1;
                    next_s.ai_pos = ai_ack;
                end
                if (ul_edge) begin
                    if (s.slot_cnt != 3'h7) begin
                        next_s.slot_cnt = s.slot_cnt + 3'h1;
                    end
                    if (s.slot_cnt + 3'h1 >= spacing) begin // R16 R17
                        if (s.ai_got && !s.ai_pos) begin
                            // negative answer ends the attempt
                            next_s.fail = 1'b1;
                            next_s.ra = RA_IDLE;
                        end else if (gap_ok) begin // R19 R20
                            if (s.ai_got) begin
                                next_s.message = 1'b1;
                                next_s.ra = RA_IDLE;
                            end else if (preamble_req) begin
                                next_s.preamble = 1'b1; // R14
                                next_s.slot_cnt = 3'h0;
                            end else begin
                                next_s.ra = RA_IDLE;
                            end
                        end
                    end
                end
            end
        endcase

        // uplink dedicated frame: count the offset from the earliest path
        if (ded_frame_sync) begin
            next_s.ul_pend = 1'b1; // R05
            next_s.ul_wait = uplink_frame_offset;
        end else if (s.ul_pend && chip_en) begin
            if (s.ul_wait == 16'h0) begin
                next_s.ul_pend = 1'b0;
            end else begin
                next_s.ul_wait = s.ul_wait - 16'h1;
            end
        end

        // handover: chips from the target primary frame to the dedicated path
        if (target_frame_sync) begin
            next_s.meas_busy = 1'b1;
            next_s.meas_cnt = 16'h0;
        end else if (s.meas_busy) begin
            if (ded_frame_sync) begin
                next_s.ho_diff = s.meas_cnt; // R07
                next_s.ho_valid = 1'b1;
                next_s.meas_busy = 1'b0;
            end else if (chip_en && s.meas_cnt != 16'hFFFF) begin
                next_s.meas_cnt = s.meas_cnt + 16'h1;
            end
        end

        // shared frame carrying the data: past 35840 chips the dedicated
        // frame runs ahead and belongs to the next shared frame
        if (ded_frame_sync) begin
            next_s.shared_ahead = ded_pos > `SHARED_BEHIND_MAX; // R11
            next_s.shared_frame = (ded_pos > `SHARED_BEHIND_MAX) ?
                sfn_step(dl_if.frame, SFN_MOD) : dl_if.frame;
            next_s.shared_valid = 1'b1;
        end

        // paging: a set indicator calls for the secondary frame a lead later
        if (paging_frame_start) begin
            next_s.pg_busy = 1'b1;
            next_s.pg_cnt = 13'h0;
            next_s.pg_hit = pi_valid && pi_value;
        end else if (s.pg_busy) begin
            if (pi_valid && pi_value) begin
                next_s.pg_hit = 1'b1;
            end
            if (chip_en) begin
                if (s.pg_cnt == `PAGING_LEAD_LAST) begin
                    next_s.pg_busy = 1'b0;
                    next_s.pg_read = s.pg_hit; // R22
                end else begin
                    next_s.pg_cnt = s.pg_cnt + 13'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs, each from a flip-flop here or in a counter
    assign dl_slot_start = dl_if.slot_start;
    assign dl_frame_start = dl_if.frame_start;
    assign system_frame_counter = dl_if.frame;
    assign dl_access_start = s.dl_acc;
    assign ul_access_start = s.ul_acc;
    // one frame strobe serves control and data channels alike
    assign ul_frame_start = ul_if.frame_start; // R08
    assign ul_scramble_init = ul_if.frame_start; // R06
    assign preamble_start = s.preamble;
    assign message_start = s.message;
    assign ra_fail = s.fail;
    assign handover_timing_difference = s.ho_diff;
    assign handover_valid = s.ho_valid;
    assign shared_frame_number = s.shared_frame;
    assign shared_ahead = s.shared_ahead;
    assign shared_valid = s.shared_valid;
    assign read_secondary_frame = s.pg_read;

    //////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence ul_slot_seen;
        ul_access_start && dl_if.slot[0] != dl_if.frame[0];
    endsequence

    AST_PREAMBLE_ON_SLOT: assert property (preamble_start |-> ul_slot_seen) // R14
        else $error("preamble off the uplink access slot");
    AST_ACCESS_OFFSET: assert property (dl_access_start |-> !ul_access_start ##1 !ul_access_start) // R15
        else $error("uplink access slot not offset from downlink");
    AST_SCRAMBLE_PHASE: assert property (ul_scramble_init |-> ul_if.chip == 12'h0 && ul_if.slot == 4'h0) // R06
        else $error("scrambling restart off the uplink frame");
    AST_UL_AFTER_OFFSET: assert property (ul_go |=> ul_frame_start && !s.ul_pend) // R05
        else $error("uplink frame not started after offset");
    AST_PREAMBLE_GAP: assert property (preamble_start |-> !$past(s.ai_recent) && !$past(ai_valid)) // R19
        else $error("preamble too close to indicator");
    AST_MESSAGE_GAP: assert property (message_start |-> !$past(s.ai_recent) && $past(s.ai_pos)) // R20
        else $error("message too close to indicator");
    AST_RETRY_SPACING: assert property ( // R16
        preamble_start && $past(s.ra) == RA_SPACING |->
        $past(s.slot_cnt) + 3'h1 >= ($past(ai_timing_sel) ? 3'h4 : 3'h3))
        else $error("preamble retry spacing short");
    AST_MESSAGE_SPACING: assert property ( // R17
        message_start |-> $past(s.slot_cnt) + 3'h1 >= ($past(ai_timing_sel) ? 3'h4 : 3'h3))
        else $error("message spacing short");
    AST_HANDOVER_REPORT: assert property ($past(s.meas_busy) && $past(ded_frame_sync) |-> // R07
        handover_valid && handover_timing_difference == $past(s.meas_cnt))
        else $error("handover difference not reported");
    AST_PAGING_READ: assert property (read_secondary_frame |-> $past(s.pg_hit) && !s.pg_busy) // R22
        else $error("secondary frame read without indicator");
endmodule

// ### base_station_model.sv
`timescale 1ns/1ns
module base_station_model (
    input wire logic core_clk,
    input wire logic preamble_start,
    input wire logic ai_timing_sel,
    input wire logic [1:0] ai_mode,
    output logic cell_frame_sync,
    output logic sfn_load,
    output logic [15:0] sfn_value,
    output logic ded_frame_sync,
    output logic target_frame_sync,
    output logic ai_valid,
    output logic ai_ack,
    output logic paging_frame_start,
    output logic pi_valid,
    output logic pi_value
);
    int dly;

    // quiet air until the bench asks for something
    initial begin
        {cell_frame_sync, sfn_load, ded_frame_sync, target_frame_sync} = 4'h0;
        {ai_valid, ai_ack, paging_frame_start, pi_valid, pi_value} = 5'h00;
        sfn_value = 16'h0000;
    end

    //////////////////////////////
    // one-cycle strobes, cleared one clock later so the edge sees them once
    task automatic send(input int k, input logic [15:0] v);
        @(posedge core_clk);
        #1;
        case (k)
            0: begin
                cell_frame_sync = 1'b1;
                cell_frame_sync <= #20 1'b0;
            end
            1: begin
                sfn_value = v;
                sfn_load = 1'b1;
                sfn_load <= #20 1'b0;
            end
            2: begin
                ded_frame_sync = 1'b1;
                ded_frame_sync <= #20 1'b0;
            end
            3: begin
                target_frame_sync = 1'b1;
                target_frame_sync <= #20 1'b0;
            end
            default: begin
                paging_frame_start = 1'b1;
                pi_valid = 1'b1;
                pi_value = v[0];
                {paging_frame_start, pi_valid} <= #20 2'h0;
            end
        endcase
    endtask

    // indicator answer; mode 0 stays silent, 1 acks, 2 refuses
    always begin
        @(posedge core_clk);
        if (preamble_start === 1'b1 && ai_mode != 2'h0) begin
            dly = ai_timing_sel ? 12800 : 7680;
            repeat (dly - 2) @(posedge core_clk);
            #1;
            ai_valid = 1'b1;
            ai_ack = (ai_mode == 2'h1);
            @(posedge core_clk);
            #1;
            ai_valid = 1'b0;
            ai_ack = 1'b0;
        end
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic core_clk, srst, chip_en, preamble_req, ai_timing_sel;
    logic [15:0] uplink_frame_offset;
    logic [1:0] ai_mode;
    logic cell_frame_sync, sfn_load, ded_frame_sync, target_frame_sync;
    logic ai_valid, ai_ack, paging_frame_start, pi_valid, pi_value;
    logic [15:0] sfn_value, system_frame_counter, handover_timing_difference, shared_frame_number;
    logic dl_slot_start, dl_frame_start, dl_access_start, ul_access_start, ul_frame_start;
    logic ul_scramble_init, preamble_start, message_start, ra_fail, handover_valid;
    logic shared_ahead, shared_valid, read_secondary_frame;
    int cyc, failures, num_checks;
    int t0, tc, ta, tu, tx, td, th, ts, tf, tn, tp, tp2, tm, tr, tq, tg;

    // short frame counter modulus keeps the wrap reachable
    radio_frame_timing #(.SFN_MOD(16'h0048)) radio_frame_timing_i (.core_clk(core_clk), .srst(srst),
        .chip_en(chip_en), .cell_frame_sync(cell_frame_sync), .sfn_load(sfn_load), .sfn_value(sfn_value),
        .ded_frame_sync(ded_frame_sync), .target_frame_sync(target_frame_sync),
        .uplink_frame_offset(uplink_frame_offset), .ai_timing_sel(ai_timing_sel), .preamble_req(preamble_req),
        .ai_valid(ai_valid), .ai_ack(ai_ack), .paging_frame_start(paging_frame_start), .pi_valid(pi_valid),
        .pi_value(pi_value), .dl_slot_start(dl_slot_start), .dl_frame_start(dl_frame_start),
        .system_frame_counter(system_frame_counter), .dl_access_start(dl_access_start),
        .ul_access_start(ul_access_start), .ul_frame_start(ul_frame_start), .ul_scramble_init(ul_scramble_init),
        .preamble_start(preamble_start), .message_start(message_start), .ra_fail(ra_fail),
        .handover_timing_difference(handover_timing_difference), .handover_valid(handover_valid),
        .shared_frame_number(shared_frame_number), .shared_ahead(shared_ahead), .shared_valid(shared_valid),
        .read_secondary_frame(read_secondary_frame));

    base_station_model base_station_model_i (.core_clk(core_clk), .preamble_start(preamble_start),
        .ai_timing_sel(ai_timing_sel), .ai_mode(ai_mode), .cell_frame_sync(cell_frame_sync), .sfn_load(sfn_load),
        .sfn_value(sfn_value), .ded_frame_sync(ded_frame_sync), .target_frame_sync(target_frame_sync),
        .ai_valid(ai_valid), .ai_ack(ai_ack), .paging_frame_start(paging_frame_start), .pi_valid(pi_valid),
        .pi_value(pi_value));

    //////////////////////////////
    // clock and edge count used as the time base for every figure
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    function automatic logic ev(input int k);
        case (k)
            0: return dl_frame_start;
            1: return dl_access_start;
            2: return ul_access_start;
            3: return preamble_start;
            4: return message_start;
            5: return ra_fail;
            6: return ul_frame_start;
            7: return handover_valid;
            8: return shared_valid;
            default: return read_secondary_frame;
        endcase
    endfunction

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string what);
        num_checks++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    // bounded wait; a missed must-see event ends the run at once
    task automatic wait_ev(input int k, input int bound, input bit must, output int t);
        t = -1;
        for (int i = 0; i < bound && t < 0; i++) begin
            @(posedge core_clk);
            #1;
            if (ev(k) === 1'b1) t = cyc;
        end
        if (must && t < 0) begin
            failures++;
            $display("[ERR] %0t wait for event %0d expired", $time, k);
            complete_run();
        end
    endtask

    task automatic until_cyc(input int n);
        while (cyc < n) @(posedge core_clk);
    endtask

    //////////////////////////////
    initial begin
        core_clk = 1'b0;
        cyc = 0;
        failures = 0;
        num_checks = 0;
        {srst, chip_en, preamble_req, ai_timing_sel, ai_mode} = 6'h30;
        uplink_frame_offset = 16'h0064;
        repeat (12) @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk(system_frame_counter === 16'h0000 && preamble_start === 1'b0 && ul_frame_start === 1'b0, "reset");
        $display("test reset done");
        // load the wrap value, then the cell sync steps it over the modulus
        base_station_model_i.send(1, 16'h0047);
        base_station_model_i.send(0, 16'h0000);
        tc = cyc + 1;
        wait_ev(0, 4, 1, t0);
        chk(t0 - tc === 0 && system_frame_counter === 16'h0000 && dl_slot_start === 1'b1, "frame restart or wrap");
        wait_ev(1, 4, 1, ta);
        chk(ta - t0 === 1, "downlink access slot not on frame");
        wait_ev(2, 2600, 1, tu);
        chk(tu - ta === 2560, "uplink access offset");
        wait_ev(1, 5200, 1, tq);
        chk(tq - ta === 5120, "access slot length");
        $display("test grid done");
        // measurement, shared frame and uplink frame from one dedicated sync
        until_cyc(t0 + 6000);
        base_station_model_i.send(3, 16'h0000);
        tx = cyc + 1;
        until_cyc(t0 + 6500);
        base_station_model_i.send(2, 16'h0000);
        td = cyc + 1;
        fork
            wait_ev(7, 4, 1, th);
            wait_ev(8, 4, 1, ts);
            wait_ev(6, 110, 1, tf);
        join
        chk(handover_timing_difference >= 16'h01F3 && handover_timing_difference <= 16'h01F5, "handover");
        chk(shared_ahead === 1'b0 && shared_frame_number === 16'h0000, "shared frame behind");
        chk(tf - td === 101 || tf - td === 102, "uplink frame offset");
        chk(ul_scramble_init === 1'b1, "scrambling phase");
        // late sync: shared frame is the next one, uplink grid reloads
        until_cyc(t0 + 37000);
        base_station_model_i.send(2, 16'h0000);
        td = cyc + 1;
        fork
            wait_ev(7, 4, 0, th);
            wait_ev(8, 4, 1, ts);
            wait_ev(6, 110, 1, tf);
        join
        chk(th < 0, "report without measurement");
        chk(shared_ahead === 1'b1 && shared_frame_number === 16'h0001, "shared frame ahead");
        chk(tf - td === 101 || tf - td === 102, "uplink frame reload");
        wait_ev(0, 1500, 1, tn);
        chk(tn - t0 === 38400 && system_frame_counter === 16'h0001, "frame length");
        $display("test frame relations done");
        fork
            begin
                // silent base station, then a positive answer
                preamble_req = 1'b1;
                wait_ev(3, 5200, 1, tp);
                chk(ul_access_start === 1'b1 && (tp - t0) % 5120 === 2561, "preamble slot");
                wait_ev(3, 15400, 1, tp2);
                chk(tp2 - tp === 15360, "repeat preamble spacing");
                ai_mode = 2'h1;
                wait_ev(4, 15400, 1, tm);
                chk(tm - tp2 === 15360, "message spacing");
                preamble_req = 1'b0;
                // long indicator timing with a refusal
                ai_timing_sel = 1'b1;
                ai_mode = 2'h2;
                preamble_req = 1'b1;
                wait_ev(3, 5200, 1, tp);
                wait_ev(5, 20500, 1, tr);
                chk(tr - tp === 20480, "refusal spacing");
                preamble_req = 1'b0;
                $display("test random access done");
            end
            begin
                base_station_model_i.send(4, 16'h0001);
                tq = cyc + 1;
                wait_ev(9, 7700, 1, tg);
                chk(tg - tq === 7680 || tg - tq === 7681, "paging lead");
                base_station_model_i.send(4, 16'h0000);
                wait_ev(9, 7700, 0, tg);
                chk(tg < 0, "read without indicator");
                $display("test paging done");
            end
        join
        complete_run();
    end
endmodule
